// File: bds_consts.svh
// Constants of the button and divider sequencer: register offsets,
// field positions, reset values and timing counts.
// Assumes a 20 MHz system clock.
`ifndef BDS_CONSTS_SVH
`define BDS_CONSTS_SVH
// Register byte offsets
`define BDS_OFS_CTRL     8'h00
`define BDS_OFS_TIMING   8'h04
`define BDS_OFS_LEVELS   8'h08
`define BDS_OFS_EVENT    8'h0c
`define BDS_OFS_MASK     8'h10
`define BDS_OFS_FAULT    8'h14
`define BDS_OFS_STATUS   8'h18
// Event, mask and fault record bit positions
`define BDS_EV_BUTTON    0
`define BDS_EV_LONG      1
`define BDS_EV_OCWARN    2
`define BDS_FL_ILIM      0
`define BDS_FL_RAMPUP    1
`define BDS_FL_LONG      2
`define BDS_FL_OCALARM   8
// Reset values
`define BDS_CTRL_RST     32'h0000_0001
`define BDS_TIMING_RST   32'h0a64_6414
`define BDS_LEVELS_RST   32'h1e32_1e28
`define BDS_MASK_RST     3'h0
// Timing
`define BDS_CLK_NS       50
`define BDS_TICK_NS      1000000
`define BDS_MS_CYC       (`BDS_TICK_NS / `BDS_CLK_NS)
`define BDS_RAMP_MS      10'd20
`define BDS_LONG_MS      10'd1000
// Voltage figures in mV
`define BDS_RESTART_MV   14'd1000
`define BDS_CCM_FIX_MV   14'd30
`define BDS_NEAR_MV      14'd80
// Bus responses
`define BDS_RESP_OK      2'b00
`define BDS_RESP_DECERR  2'b11
`endif

// File: bds_pkg.sv
// Types shared by the button and divider sequencer.
// Assumes bds_consts.svh for numeric constants.
package bds_pkg;
   typedef enum logic [5:0] {
      ST_PDOWN  = 6'b000001,
      ST_IDLE   = 6'b000010,
      ST_CHARGE = 6'b000100,
      ST_RUN    = 6'b001000,
      ST_FAULT  = 6'b010000,
      ST_DISCH  = 6'b100000
   } bds_state_t;

   // Control register, bit 0 at the bottom
   typedef struct packed {
      logic [19:0] rsvd;
      logic [3:0]  charge_code;
      logic        rsvd7;
      logic        pairing_link_enable;
      logic        button_edge_select;
      logic        long_press_target_select;
      logic        sleep;
      logic        ccm_active_auto_sleep;
      logic        converter_frequency_mode;
      logic        conv_en;
   } bds_ctrl_t;
endpackage : bds_pkg

// File: bds_seq.sv
// Button and divider sequencer: power-button handling, power states
// and start-up / power-down sequencing of the divider converter.
// Assumes voltages arrive as synchronous mV codes from an ADC, inputs
// synchronous to SYS_CLK, AXI4-Lite master for registers.
//
// Operation
// - Button press sets maskable event and interrupt
// - Debounced press wakes from power-down
// - After wake, events wait for release; the long-press event can still fire before release
// - Long press starts power cycle to target
// - Cycle after 1 s unless event cleared
// - Level enable mode follows pin level
// - Level drop skips fault wait state
// - Start-up charges with switching held off
// - 20 ms ramp timeout logs failure
// - Mode field picks fixed or automatic
// - Automatic mode DCM with hysteresis
// - Enable on active; CCM active, auto sleep
// - Master enables slave below trigger level
// - Master releases slave above level plus hysteresis
// - Master disable shuts slave down
// - Trigger level from half battery minus drops
// - Power-down pull-down, restart below 1 V
// - Paired power-down synchronised, master discharges
// - Current limit enters fault recovery
// - Overcurrent warning event, alarm readable
// - Edge select picks falling or rising event
// - Write one clears fault record bit
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "bds_consts.svh"

module bds_seq #(
   parameter int MS_CYC = `BDS_MS_CYC
) (
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   input  wire logic        POWER_BUTTON_PIN_N,
   input  wire logic        BUTTON_PIN_FUNCTION,
   input  wire logic        AUTO_START_ON_SUPPLY,
   input  wire logic [13:0] VBAT_MV,
   input  wire logic [13:0] VOUT_MV,
   input  wire logic        ILIM_HIT,
   input  wire logic        OC_ALARM,
   output logic             SWITCH_EN,
   output logic             CHARGE_EN,
   output logic [3:0]       STARTUP_CHARGE_CURRENT,
   output logic             DCM_MODE,
   output logic             PULLDOWN_EN,
   output logic             PAIR_SLAVE_EN,
   output logic             PAIR_PD_SYNC,
   output logic             ACTIVE_MODE,
   output logic             BUTTON_IRQ,
   output logic [13:0]      SLAVE_TRIGGER_LEVEL,
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY
);

   function automatic logic [13:0] sub_sat(input logic [13:0] a,
                                           input logic [13:0] b);
      sub_sat = (a >= b) ? a - b : 14'h0;
   endfunction : sub_sat

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0]  stb);
      logic [31:0] m;
      m = {{8{stb[3]}}, {8{stb[2]}}, {8{stb[1]}}, {8{stb[0]}}};
      merge = (old & ~m) | (dat & m);
   endfunction : merge

   bds_pkg::bds_state_t st_reg, st_next;
   bds_pkg::bds_ctrl_t  ctrl_reg;
   logic [31:0] timing_reg, levels_reg;
   logic [2:0]  ev_reg, mask_reg;
   logic [2:0]  fault_reg;
   logic        to_pd_reg, to_pd_next;
   logic        boot_reg, level_mode_reg;
   logic        sync1_reg, sync2_reg, deb_reg;
   logic [7:0]  deb_cnt_reg;
   logic [31:0] ms_cnt_reg;
   logic [9:0]  press_ms_reg, lp_cnt_reg, st_ms_reg;
   logic        lp_arm_reg, wake_blk_reg, oc_d_reg;
   logic        slave_en_reg, dcm_reg;
   logic [13:0] trig_reg;

   // Register bus state
   logic        aw_ok_reg, w_ok_reg, bvalid_reg, rvalid_reg;
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg, rdata_reg;
   logic [3:0]  w_strb_reg;
   logic [1:0]  bresp_reg, rresp_reg;

   // Timing fields in ms
   wire [7:0] deb_ms   = timing_reg[7:0];
   wire [7:0] key_ms   = timing_reg[15:8];
   wire [7:0] shut_ms  = timing_reg[23:16];
   wire [7:0] fault_ms = timing_reg[31:24];
   wire [9:0] lp_lim   = {2'b00, key_ms} + {2'b00, shut_ms};

   // Millisecond tick shared by all long timers keeps counters small
   wire tick = (ms_cnt_reg == 32'(MS_CYC - 1));

   // Comparator levels, all mV
   wire [13:0] half_mv  = {1'b0, VBAT_MV[13:1]};
   wire [13:0] dcm_lvl  = sub_sat(half_mv, {6'h0, levels_reg[7:0]});
   wire [13:0] dcm_lo   = sub_sat(dcm_lvl, {6'h0, levels_reg[15:8]});
   wire [13:0] ccm_lvl  = sub_sat(dcm_lvl, `BDS_CCM_FIX_MV);
   wire [13:0] trig_lvl = sub_sat(ccm_lvl,
                                  {6'h0, levels_reg[23:16]});
   wire [13:0] rel_lvl  = trig_reg + {6'h0, levels_reg[31:24]};
   wire [13:0] near_lvl = sub_sat(half_mv, `BDS_NEAR_MV);
   wire        below_1v = (VOUT_MV < `BDS_RESTART_MV);
   wire        near_ok  = (VOUT_MV >= near_lvl);

   // Mode decode
   wire in_pdown  = (st_reg == bds_pkg::ST_PDOWN);
   wire in_idle   = (st_reg == bds_pkg::ST_IDLE);
   wire in_charge = (st_reg == bds_pkg::ST_CHARGE);
   wire in_run    = (st_reg == bds_pkg::ST_RUN);
   wire in_fault  = (st_reg == bds_pkg::ST_FAULT);
   wire in_disch  = (st_reg == bds_pkg::ST_DISCH);
   wire active    = in_idle | in_charge | in_run;

   // Button decode: the pin is low while pressed
   wire pressed   = ~deb_reg;
   wire deb_set   = tick & (sync2_reg != deb_reg) &
                    (deb_cnt_reg >= deb_ms);
   wire fall_edge = deb_set & deb_reg;
   wire rise_edge = deb_set & ~deb_reg;
   wire btn_edge  = ctrl_reg.button_edge_select ? rise_edge
                                                : fall_edge;
   wire btn_fire  = active & btn_edge & ~wake_blk_reg;
   wire lvl_low   = level_mode_reg & ~deb_reg;
   wire lp_fire   = active & ~level_mode_reg & pressed & tick &
                    (press_ms_reg == lp_lim);
   wire cycle_go  = lp_arm_reg & tick &
                    (lp_cnt_reg == `BDS_LONG_MS - 10'd1);
   wire oc_fire   = OC_ALARM & ~oc_d_reg;
   wire ramp_out  = tick & (st_ms_reg >= `BDS_RAMP_MS - 10'd1);

   // Frequency mode: the option forces CCM while active
   wire auto_mode = ctrl_reg.ccm_active_auto_sleep ? ctrl_reg.sleep
                  : ctrl_reg.converter_frequency_mode;

   // Register bus decode
   wire do_wr = aw_ok_reg & w_ok_reg & ~bvalid_reg;
   wire do_rd = S_AXI_ARVALID & ~rvalid_reg;
   wire wr_ctrl  = do_wr & (aw_addr_reg == `BDS_OFS_CTRL);
   wire wr_tim   = do_wr & (aw_addr_reg == `BDS_OFS_TIMING);
   wire wr_lvl   = do_wr & (aw_addr_reg == `BDS_OFS_LEVELS);
   wire wr_ev    = do_wr & (aw_addr_reg == `BDS_OFS_EVENT);
   wire wr_mask  = do_wr & (aw_addr_reg == `BDS_OFS_MASK);
   wire wr_fault = do_wr & (aw_addr_reg == `BDS_OFS_FAULT);
   wire wr_hit   = wr_ctrl | wr_tim | wr_lvl | wr_ev | wr_mask |
                   wr_fault | (aw_addr_reg == `BDS_OFS_STATUS);
   wire [31:0] w1c = merge(32'h0, w_data_reg, w_strb_reg);
   wire [2:0]  ev_set = {oc_fire, lp_fire, btn_fire};
   wire [2:0]  fl_set = {cycle_go & ~ILIM_HIT,
                         in_charge & ~near_ok & ramp_out & ~ILIM_HIT,
                         (in_charge | in_run) & ILIM_HIT};
   wire [31:0] status_w = {21'h0, dcm_reg, slave_en_reg, deb_reg,
                           2'b00, st_reg};
   wire [31:0] fault_w  = {23'h0, OC_ALARM, 5'h0, fault_reg};
   wire        rd_hit;
   wire [31:0] rd_mux;
   assign rd_hit = (S_AXI_ARADDR <= `BDS_OFS_STATUS) &
                   (S_AXI_ARADDR[1:0] == 2'b00);
   assign rd_mux =
      (S_AXI_ARADDR == `BDS_OFS_CTRL)   ? ctrl_reg :
      (S_AXI_ARADDR == `BDS_OFS_TIMING) ? timing_reg :
      (S_AXI_ARADDR == `BDS_OFS_LEVELS) ? levels_reg :
      (S_AXI_ARADDR == `BDS_OFS_EVENT)  ? {29'h0, ev_reg} :
      (S_AXI_ARADDR == `BDS_OFS_MASK)   ? {29'h0, mask_reg} :
      (S_AXI_ARADDR == `BDS_OFS_FAULT)  ? fault_w :
      (S_AXI_ARADDR == `BDS_OFS_STATUS) ? status_w : 32'h0;

   // Power state sequencing
   always_comb begin
      st_next    = st_reg;
      to_pd_next = to_pd_reg;
      unique case (st_reg)
         bds_pkg::ST_PDOWN: begin
            if (boot_reg) begin
               // Auto start on supply is ignored in level mode
               if (AUTO_START_ON_SUPPLY & ~BUTTON_PIN_FUNCTION)
                  st_next = bds_pkg::ST_IDLE;
            end else if (level_mode_reg ? deb_reg : pressed) begin
               st_next = bds_pkg::ST_IDLE;
            end
         end
         bds_pkg::ST_IDLE: begin
            if (lvl_low) begin
               st_next = bds_pkg::ST_PDOWN;
            end else if (cycle_go) begin
               st_next    = bds_pkg::ST_DISCH;
               to_pd_next = ctrl_reg.long_press_target_select;
            end else if (ctrl_reg.conv_en & below_1v) begin
               st_next = bds_pkg::ST_CHARGE;
            end
         end
         bds_pkg::ST_CHARGE, bds_pkg::ST_RUN: begin
            if (ILIM_HIT) begin
               st_next = bds_pkg::ST_FAULT;
            end else if (lvl_low) begin
               st_next    = bds_pkg::ST_DISCH;
               to_pd_next = 1'b1;
            end else if (cycle_go) begin
               st_next    = bds_pkg::ST_DISCH;
               to_pd_next = ctrl_reg.long_press_target_select;
            end else if (~ctrl_reg.conv_en) begin
               st_next    = bds_pkg::ST_DISCH;
               to_pd_next = 1'b0;
            end else if (in_charge & near_ok) begin
               st_next = bds_pkg::ST_RUN;
            end else if (in_charge & ramp_out) begin
               st_next = bds_pkg::ST_FAULT;
            end
         end
         bds_pkg::ST_FAULT: begin
            // Fault wait lets the application discharge
            if (tick & (st_ms_reg >= {2'b00, fault_ms})) begin
               st_next    = bds_pkg::ST_DISCH;
               to_pd_next = 1'b0;
            end
         end
         bds_pkg::ST_DISCH: begin
            if (below_1v)
               st_next = to_pd_reg ? bds_pkg::ST_PDOWN
                                   : bds_pkg::ST_IDLE;
         end
         default: st_next = bds_pkg::ST_PDOWN;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_reg    <= bds_pkg::ST_PDOWN;
         to_pd_reg <= 1'b0;
         boot_reg  <= 1'b1;
         st_ms_reg <= 10'h0;
      end else begin
         st_reg    <= st_next;
         to_pd_reg <= to_pd_next;
         boot_reg  <= 1'b0;
         if (st_next != st_reg)
            st_ms_reg <= 10'h0;
         else if (tick & (st_ms_reg != 10'h3ff))
            st_ms_reg <= st_ms_reg + 10'd1;
      end
   end

   // Strap is caught on the first clock after reset release
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N)
         level_mode_reg <= 1'b0;
      else if (boot_reg)
         level_mode_reg <= BUTTON_PIN_FUNCTION;
   end

   // Synchroniser, tick and debounce
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sync1_reg   <= 1'b1;
         sync2_reg   <= 1'b1;
         deb_reg     <= 1'b1;
         deb_cnt_reg <= 8'h0;
         ms_cnt_reg  <= 32'h0;
      end else begin
         sync1_reg  <= POWER_BUTTON_PIN_N;
         sync2_reg  <= sync1_reg;
         ms_cnt_reg <= tick ? 32'h0 : ms_cnt_reg + 32'h1;
         if (sync2_reg == deb_reg)
            deb_cnt_reg <= 8'h0;
         else if (deb_set)
            deb_cnt_reg <= 8'h0;
         else if (tick & (deb_cnt_reg != 8'hff))
            deb_cnt_reg <= deb_cnt_reg + 8'h1;
         if (deb_set)
            deb_reg <= sync2_reg;
      end
   end

   // Press timing, wake block and long-press countdown
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         press_ms_reg <= 10'h0;
         lp_cnt_reg   <= 10'h0;
         lp_arm_reg   <= 1'b0;
         wake_blk_reg <= 1'b0;
         oc_d_reg     <= 1'b0;
      end else begin
         oc_d_reg <= OC_ALARM;
         if (~(active & pressed))
            press_ms_reg <= 10'h0;
         else if (tick & (press_ms_reg != 10'h3ff))
            press_ms_reg <= press_ms_reg + 10'd1;
         if (in_pdown & (st_next == bds_pkg::ST_IDLE) &
             ~level_mode_reg & ~boot_reg)
            wake_blk_reg <= 1'b1;
         else if (rise_edge)
            wake_blk_reg <= 1'b0;
         if (lp_fire) begin
            lp_arm_reg <= 1'b1;
            lp_cnt_reg <= 10'h0;
         end else if (~ev_reg[`BDS_EV_LONG] | cycle_go | ~active) begin
            lp_arm_reg <= 1'b0;
         end else if (lp_arm_reg & tick) begin
            lp_cnt_reg <= lp_cnt_reg + 10'd1;
         end
      end
   end

   // Converter comparators: DCM hysteresis and slave trigger
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         dcm_reg      <= 1'b0;
         slave_en_reg <= 1'b0;
         trig_reg     <= 14'h0;
      end else begin
         trig_reg <= trig_lvl;
         if (~in_run)
            dcm_reg <= 1'b0;
         else if (VOUT_MV > dcm_lvl)
            dcm_reg <= 1'b1;
         else if (VOUT_MV < dcm_lo)
            dcm_reg <= 1'b0;
         if (~(in_run & ctrl_reg.pairing_link_enable))
            slave_en_reg <= 1'b0;
         else if (VOUT_MV < trig_reg)
            slave_en_reg <= 1'b1;
         else if (VOUT_MV > rel_lvl)
            slave_en_reg <= 1'b0;
      end
   end

   // Software registers; a hardware set wins over a same-cycle clear
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_reg   <= `BDS_CTRL_RST;
         timing_reg <= `BDS_TIMING_RST;
         levels_reg <= `BDS_LEVELS_RST;
         mask_reg   <= `BDS_MASK_RST;
         ev_reg     <= 3'h0;
         fault_reg  <= 3'h0;
      end else begin
         if (wr_ctrl)
            ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg);
         if (wr_tim)
            timing_reg <= merge(timing_reg, w_data_reg, w_strb_reg);
         if (wr_lvl)
            levels_reg <= merge(levels_reg, w_data_reg, w_strb_reg);
         if (wr_mask & w_strb_reg[0])
            mask_reg <= w_data_reg[2:0];
         ev_reg    <= (ev_reg & ~({3{wr_ev}} & w1c[2:0])) | ev_set;
         fault_reg <= (fault_reg & ~({3{wr_fault}} & w1c[2:0]))
                      | fl_set;
      end
   end

   // AXI4-Lite slave: address and data taken in either order
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         aw_ok_reg   <= 1'b0;
         w_ok_reg    <= 1'b0;
         aw_addr_reg <= 8'h0;
         w_data_reg  <= 32'h0;
         w_strb_reg  <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `BDS_RESP_OK;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0;
         rresp_reg   <= `BDS_RESP_OK;
      end else begin
         if (S_AXI_AWVALID & S_AXI_AWREADY) begin
            aw_ok_reg   <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR;
         end else if (do_wr) begin
            aw_ok_reg <= 1'b0;
         end
         if (S_AXI_WVALID & S_AXI_WREADY) begin
            w_ok_reg   <= 1'b1;
            w_data_reg <= S_AXI_WDATA;
            w_strb_reg <= S_AXI_WSTRB;
         end else if (do_wr) begin
            w_ok_reg <= 1'b0;
         end
         if (do_wr) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? `BDS_RESP_OK : `BDS_RESP_DECERR;
         end else if (S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
         end
         if (do_rd) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_hit ? rd_mux : 32'h0;
            rresp_reg  <= rd_hit ? `BDS_RESP_OK : `BDS_RESP_DECERR;
         end else if (S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   assign S_AXI_AWREADY = ~aw_ok_reg & ~bvalid_reg;
   assign S_AXI_WREADY  = ~w_ok_reg & ~bvalid_reg;
   assign S_AXI_BVALID  = bvalid_reg;
   assign S_AXI_BRESP   = bresp_reg;
   assign S_AXI_ARREADY = ~rvalid_reg;
   assign S_AXI_RVALID  = rvalid_reg;
   assign S_AXI_RDATA   = rdata_reg;
   assign S_AXI_RRESP   = rresp_reg;

   // Outputs decode from state, control, event and comparator flops
   assign SWITCH_EN   = in_run;
   assign CHARGE_EN   = in_charge;
   assign STARTUP_CHARGE_CURRENT = ctrl_reg.charge_code;
   assign DCM_MODE    = auto_mode & dcm_reg;
   assign PULLDOWN_EN = in_disch;
   assign PAIR_PD_SYNC = in_disch & ctrl_reg.pairing_link_enable;
   assign PAIR_SLAVE_EN = slave_en_reg;
   assign ACTIVE_MODE = active;
   assign BUTTON_IRQ  = |(ev_reg & ~mask_reg);
   assign SLAVE_TRIGGER_LEVEL = trig_reg;

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_N);

   charge_hold_a: assert property (in_charge |-> !SWITCH_EN && CHARGE_EN
      && PULLDOWN_EN == 1'b0) else $error("switching during charge");
   ramp_log_a: assert property (in_charge && !ILIM_HIT && !near_ok &&
      ramp_out && !lvl_low && !cycle_go && ctrl_reg.conv_en
      |=> in_fault && fault_reg[`BDS_FL_RAMPUP])
      else $error("ramp timeout not logged");
   ilim_fault_a: assert property ((in_run || in_charge) && ILIM_HIT
      |=> in_fault && fault_reg[`BDS_FL_ILIM])
      else $error("current limit missed");
   restart_gate_a: assert property (in_disch && !below_1v
      |=> in_disch) else $error("restart above 1 V");
   slave_drop_a: assert property (!in_run |=> !PAIR_SLAVE_EN)
      else $error("slave kept on");
   level_skip_a: assert property (in_run && lvl_low && !ILIM_HIT
      |=> in_disch ##1 !in_fault) else $error("fault wait used");
   wake_press_a: assert property (in_pdown && !boot_reg &&
      !level_mode_reg && pressed |=> ACTIVE_MODE)
      else $error("no wake on press");
   button_event_a: assert property (btn_fire |=> ev_reg[0] && BUTTON_IRQ
      == |({ev_reg[2:1], 1'b1} & ~mask_reg)) else $error("event lost");
   oc_event_a: assert property ($rose(OC_ALARM) |=> ev_reg[`BDS_EV_OCWARN])
      else $error("warning event lost");
   fixed_mode_a: assert property (!auto_mode |-> !DCM_MODE)
      else $error("DCM in fixed mode");
   wake_block_a: assert property (wake_blk_reg && rise_edge
      |=> !ev_reg[0] || $past(ev_reg[0])) else $error("event too early");

   long_cycle_c: cover property (cycle_go);
   ramp_fail_c: cover property (in_charge ##1 in_fault);
   slave_on_c: cover property ($rose(PAIR_SLAVE_EN));
   wake_c: cover property (in_pdown ##1 in_idle);

endmodule : bds_seq
`default_nettype wire

// File: bds_btn.sv
// Push-button model standing at the sequencer's button pin.
// Assumes press and release requests from the bench on the clock edge.
`timescale 1ns/100ps
`default_nettype none
module bds_btn (
   input  wire logic clk,
   input  wire logic press,
   output logic      pin_n
);
   // Contact shorts the pin low; the pull-up gives high when released
   always_ff @(posedge clk) pin_n <= !press;
endmodule : bds_btn
`default_nettype wire

// File: tb_top.sv
// Self-checking bench of the button and divider sequencer.
// Assumes bds_seq with a 4-cycle ms tick and the bds_btn model.
`timescale 1ns/100ps
`default_nettype none
`include "bds_consts.svh"
module tb_top;
   logic        clk, rst_n, press, ilim, oc, func, awv, wv, br, arv, rr;
   logic [7:0]  aw, ar;
   logic [31:0] wd, rv;
   logic [1:0]  rs;
   logic [13:0] vbat, vout;
   logic [41:0] rows [8];
   wire         pin_n, awr, wrr, bv, arr, rvd, sw, chg, act, irq;
   wire         pd, pds, slv, dcm;
   wire  [3:0]  code;
   wire  [13:0] trig;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   int          failures, checked;
   bds_btn btn_u (.clk(clk), .press(press), .pin_n(pin_n));
   bds_seq #(.MS_CYC(4)) dut_u (
      .SYS_CLK(clk), .RST_N(rst_n), .POWER_BUTTON_PIN_N(pin_n),
      .BUTTON_PIN_FUNCTION(func), .AUTO_START_ON_SUPPLY(1'b0),
      .VBAT_MV(vbat), .VOUT_MV(vout), .ILIM_HIT(ilim), .OC_ALARM(oc),
      .SWITCH_EN(sw), .CHARGE_EN(chg), .STARTUP_CHARGE_CURRENT(code),
      .DCM_MODE(dcm), .PULLDOWN_EN(pd), .PAIR_SLAVE_EN(slv),
      .PAIR_PD_SYNC(pds), .ACTIVE_MODE(act), .BUTTON_IRQ(irq),
      .SLAVE_TRIGGER_LEVEL(trig),
      .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wrr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(br), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvd), .S_AXI_RREADY(rr));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input string n, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", n, e, g);
         failures++;
      end
   endtask : chk
   // Each task starts on a fresh edge so no request line moves twice
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      aw <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrr) wv <= 1'b0;
      end while (bv !== 1'b1);
      rs = bresp;
      br <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      ar <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (rvd !== 1'b1);
      d = rdata;
      rs = rresp;
      rr <= 1'b0;
   endtask : rd
   // A zero hold only releases, so press never moves twice in one step
   task automatic pulse(input int hold);
      @(posedge clk);
      press <= (hold > 0);
      repeat (hold + 1) @(posedge clk);
      press <= 1'b0;
      repeat (150) @(posedge clk);
   endtask : pulse
   task automatic end_sim;
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      end_sim();
   end
   initial begin
      {rst_n, press, ilim, oc, func, awv, wv, br, arv, rr} = 10'h000;
      {aw, ar, wd} = 48'h0;
      vbat = 14'd8000;
      vout = 14'd0;
      rows = '{{`BDS_OFS_CTRL, `BDS_CTRL_RST, `BDS_RESP_OK},
         {`BDS_OFS_TIMING, `BDS_TIMING_RST, `BDS_RESP_OK},
         {`BDS_OFS_LEVELS, `BDS_LEVELS_RST, `BDS_RESP_OK},
         {`BDS_OFS_EVENT, 32'h0, `BDS_RESP_OK},
         {`BDS_OFS_MASK, 32'h0, `BDS_RESP_OK},
         {`BDS_OFS_FAULT, 32'h0, `BDS_RESP_OK},
         {`BDS_OFS_STATUS, 32'h101, `BDS_RESP_OK},
         {8'h1c, 32'h0, `BDS_RESP_DECERR}};
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         rd(rows[i][41:34], rv);
         chk("reg", rows[i][33:2], rv);
         chk("rresp", {30'h0, rows[i][1:0]}, {30'h0, rs});
      end
      wr(8'h1c, 32'hffff_ffff);
      chk("bresp", {30'h0, `BDS_RESP_DECERR}, {30'h0, rs});
      // Converter held off so the wake lands in a quiet IDLE
      wr(`BDS_OFS_CTRL, 32'h0);
      @(posedge clk);
      press <= 1'b1;
      for (int i = 0; i < 400 && act !== 1'b1; i++) @(negedge clk);
      chk("wake", 32'h1, {31'h0, act});
      rd(`BDS_OFS_STATUS, rv);
      chk("status", 32'h2, rv);
      // Rising-edge events: the release after wake must stay silent
      wr(`BDS_OFS_CTRL, 32'h20);
      pulse(0);
      rd(`BDS_OFS_EVENT, rv);
      chk("event", 32'h0, rv);
      pulse(150);
      rd(`BDS_OFS_EVENT, rv);
      chk("event", 32'h1, rv);
      chk("irq", 32'h1, {31'h0, irq});
      wr(`BDS_OFS_MASK, 32'h1);
      chk("irq", 32'h0, {31'h0, irq});
      wr(`BDS_OFS_EVENT, 32'h1);
      rd(`BDS_OFS_EVENT, rv);
      chk("event", 32'h0, rv);
      @(posedge clk);
      oc <= 1'b1;
      rd(`BDS_OFS_EVENT, rv);
      chk("event", 32'h4, rv);
      rd(`BDS_OFS_FAULT, rv);
      chk("alarm", 32'h100, rv);
      oc <= 1'b0;
      wr(`BDS_OFS_EVENT, 32'h4);
      // Auto mode, pairing link on, charge code 5
      wr(`BDS_OFS_CTRL, 32'h543);
      for (int i = 0; i < 20 && chg !== 1'b1; i++) @(negedge clk);
      chk("charge", 32'h2, {30'h0, chg, sw});
      chk("code", 32'h5, {28'h0, code});
      chk("trigger", 32'd3880, {18'h0, trig});
      @(posedge clk);
      vout <= 14'd4000;
      for (int i = 0; i < 20 && sw !== 1'b1; i++) @(negedge clk);
      chk("switch", 32'h1, {30'h0, chg, sw});
      @(negedge clk);
      chk("dcm", 32'h1, {31'h0, dcm});
      @(posedge clk);
      vout <= 14'd3800;
      repeat (2) @(negedge clk);
      chk("slave", 32'h2, {30'h0, slv, dcm});
      @(posedge clk);
      vout <= 14'd4000;
      repeat (2) @(negedge clk);
      chk("slave", 32'h1, {30'h0, slv, dcm});
      @(posedge clk);
      ilim <= 1'b1;
      repeat (2) @(negedge clk);
      chk("ilim", 32'h0, {31'h0, sw});
      rd(`BDS_OFS_FAULT, rv);
      chk("fault", 32'h1, rv);
      ilim <= 1'b0;
      wr(`BDS_OFS_FAULT, 32'h1);
      rd(`BDS_OFS_FAULT, rv);
      chk("fault", 32'h0, rv);
      repeat (60) @(negedge clk);
      chk("discharge", 32'h3, {30'h0, pd, pds});
      // Level-enable strap through a second reset; sleep stays clear
      vout <= 14'd0;
      func <= 1'b1;
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 40 && chg !== 1'b1; i++) @(negedge clk);
      chk("level", 32'h1, {31'h0, act});
      @(posedge clk);
      vout <= 14'd4000;
      @(posedge clk);
      press <= 1'b1;
      for (int i = 0; i < 400 && act !== 1'b0; i++) @(negedge clk);
      rd(`BDS_OFS_STATUS, rv);
      chk("status", 32'h20, rv);
      vout <= 14'd0;
      rd(`BDS_OFS_STATUS, rv);
      chk("status", 32'h1, rv);
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
